// ### pkg/sfa_regs.svh
`ifndef SFA_REGS_SVH
`define SFA_REGS_SVH

// saturation limits of the two word widths
`define SFA_MAX16 16'h7FFF
`define SFA_MIN16 16'h8000
`define SFA_MAX32 32'h7FFFFFFF
`define SFA_MIN32 32'h80000000

// fractional multiply scaling and rounding
`define SFA_FRAC_SH 15
`define SFA_RND 32'h00004000

// valid bits of a received sample: upper 13 of 16
`define SFA_SAMP_MASK 16'hFFF8

// issue to result, in mclk cycles
`define SFA_LATENCY 1

`endif

// ### pkg/sfa_pkg.sv
package sfa_pkg;

  // operation codes presented with each issue
  typedef enum logic [4:0] {
    SFA_OP_ADD    = 5'h00,
    SFA_OP_SUB    = 5'h01,
    SFA_OP_MULT   = 5'h02,
    SFA_OP_MULTR  = 5'h03,
    SFA_OP_ABS    = 5'h04,
    SFA_OP_DIV    = 5'h05,
    SFA_OP_LMULT  = 5'h06,
    SFA_OP_LADD   = 5'h07,
    SFA_OP_LSUB   = 5'h08,
    SFA_OP_NORM   = 5'h09,
    SFA_OP_SHL16  = 5'h0A,
    SFA_OP_SHR16  = 5'h0B,
    SFA_OP_SHL32  = 5'h0C,
    SFA_OP_SHR32  = 5'h0D,
    SFA_OP_EXT    = 5'h0E,
    SFA_OP_TRUNC  = 5'h0F,
    SFA_OP_MSAMP  = 5'h10,
    SFA_OP_MPARAM = 5'h11
  } sfa_op_t;

  // whole registered state of the unit
  typedef struct packed {
    logic vld;
    logic [31:0] res;
  } sfa_state_t;

endpackage

// ### src/sfa_div.sv
`timescale 1ns/10ps
// fractional quotient of two positive words, den >= num
module sfa_div
  import sfa_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic [W-1:0] num, // dividend, positive
  input wire logic [W-1:0] den, // divisor, not below num
  output logic [W-1:0] quo // truncated positive fraction
);

  // restoring division, one quotient bit per step, sign bit stays 0
  always_comb begin
    logic [W:0] rem;
    rem = '0;
    quo = '0;
    if (num != '0 && den != '0) begin
      rem = {1'b0, num};
      for (int i = 0; i < W - 1; i++) begin
        rem = {rem[W-1:0], 1'b0};
        quo = {quo[W-2:0], 1'b0};
        if (rem >= {1'b0, den}) begin // equal operands give ones in all 15 bits below the sign
          rem = rem - {1'b0, den};
          quo[0] = 1'b1;
        end
      end
    end
  end

endmodule // sfa_div

// ### src/sfa_alu.sv
`timescale 1ns/10ps
`include "sfa_regs.svh"
module sfa_alu
  import sfa_pkg::*;
(
  input wire logic mclk, // 10 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire logic op_valid, // issue strobe
  input wire logic [4:0] op_code, // operation select
  input wire logic [15:0] a16, // first short operand
  input wire logic [15:0] b16, // second short operand
  input wire logic [31:0] a32, // first long operand
  input wire logic [31:0] b32, // second long operand
  input wire logic b_short, // long ops take b16 sign-extended
  input wire logic [7:0] shift_n, // signed shift count, param width
  output logic res_valid, // result strobe
  output logic [31:0] res32, // long result
  output logic [15:0] res16 // short result, low half
);

  sfa_state_t st;
  sfa_state_t next_st;
  sfa_op_t op;
  logic signed [15:0] sa;
  logic signed [15:0] sb;
  logic signed [31:0] la;
  logic signed [31:0] lb;
  logic signed [31:0] prod;
  logic signed [16:0] sum16;
  logic signed [16:0] dif16;
  logic signed [32:0] sum32;
  logic signed [32:0] dif32;
  logic [15:0] quo;

  // saturate a 17-bit sum into a short word
  function automatic logic [15:0] sat16(input logic signed [16:0] v);
    if (v[16:15] == 2'b01) begin
      return `SFA_MAX16;
    end else if (v[16:15] == 2'b10) begin
      return `SFA_MIN16;
    end
    return v[15:0];
  endfunction

  // saturate a 33-bit sum into a long word
  function automatic logic [31:0] sat32(input logic signed [32:0] v);
    if (v[32:31] == 2'b01) begin
      return `SFA_MAX32;
    end else if (v[32:31] == 2'b10) begin
      return `SFA_MIN32;
    end
    return v[31:0];
  endfunction

  // shift with signed count; left fills zeros, right extends sign
  function automatic logic [31:0] shift(input logic signed [31:0] v,
                                        input logic signed [7:0] n,
                                        input logic left);
    logic signed [8:0] k;
    logic signed [8:0] m;
    k = left ? 9'(n) : -9'(n);
    m = -k;
    if (k >= 9'sh000) begin
      return (k > 9'sh01F) ? 32'h00000000 : v << k[4:0];
    end
    // both arms signed, or the whole choice turns unsigned and >>> fills zeros
    return (m > 9'sh01F) ? $signed({32{v[31]}}) : v >>> m[4:0];
  endfunction

  // shifts needed to bring a long word just under its sign bit
  function automatic logic [31:0] norm(input logic [31:0] v);
    logic [31:0] cnt;
    logic stop;
    cnt = 32'h00000000;
    stop = 1'b0;
    if (v != 32'h00000000) begin
      for (int i = 30; i >= 0; i--) begin
        if (!stop && v[i] == v[31]) begin
          cnt = cnt + 32'h00000001;
        end else begin
          stop = 1'b1;
        end
      end
    end
    return cnt;
  endfunction

  // operand shaping: long ops may take a sign-extended short constant
  assign op = sfa_op_t'(op_code);
  assign sa = a16;
  assign sb = b16;
  assign la = a32;
  assign lb = b_short ? {{16{b16[15]}}, b16} : b32;

  // shared arithmetic terms
  assign prod = sa * sb;
  assign sum16 = 17'(sa) + 17'(sb);
  assign dif16 = 17'(sa) - 17'(sb);
  assign sum32 = 33'(la) + 33'(lb);
  assign dif32 = 33'(la) - 33'(lb);

  // fractional quotient of the two short operands
  sfa_div #(
    .W(16)
  ) u_div (
    .num(a16),
    .den(b16),
    .quo(quo)
  );

  // result selection, one operation per issue
  always_comb begin
    logic signed [31:0] t;
    t = '0;
    next_st = st;
    next_st.vld = op_valid;
    if (op_valid) begin
      unique case (op)
        SFA_OP_ADD: begin
          next_st.res = {{16{sum16[16]}}, sat16(sum16)};
        end
        SFA_OP_SUB: begin
          next_st.res = {{16{dif16[16]}}, sat16(dif16)};
        end
        SFA_OP_MULT: begin
          t = prod >>> `SFA_FRAC_SH;
          next_st.res = (t == 32'sh00008000) ? 32'(`SFA_MAX16) : t;
        end
        SFA_OP_MULTR: begin
          t = (prod + $signed(`SFA_RND)) >>> `SFA_FRAC_SH; // signed sum keeps >>> arithmetic
          next_st.res = (t == 32'sh00008000) ? 32'(`SFA_MAX16) : t;
        end
        SFA_OP_ABS: begin
          if (a16 == `SFA_MIN16) begin
            next_st.res = 32'(`SFA_MAX16);
          end else begin
            next_st.res = sa[15] ? 32'(-sa) : 32'(sa);
          end
        end
        SFA_OP_DIV: begin
          next_st.res = {16'h0000, quo};
        end
        SFA_OP_LMULT: begin
          next_st.res = prod <<< 1;
        end
        SFA_OP_LADD: begin
          next_st.res = sat32(sum32);
        end
        SFA_OP_LSUB: begin
          next_st.res = sat32(dif32);
        end
        SFA_OP_NORM: begin
          next_st.res = norm(a32);
        end
        SFA_OP_SHL16: begin
          t = shift({{16{a16[15]}}, a16}, shift_n, 1'b1);
          next_st.res = {{16{t[15]}}, t[15:0]};
        end
        SFA_OP_SHR16: begin
          t = shift({{16{a16[15]}}, a16}, shift_n, 1'b0);
          next_st.res = {{16{t[15]}}, t[15:0]};
        end
        SFA_OP_SHL32: begin
          next_st.res = shift(la, shift_n, 1'b1);
        end
        SFA_OP_SHR32: begin
          next_st.res = shift(la, shift_n, 1'b0);
        end
        SFA_OP_EXT: begin
          next_st.res = {{16{a16[15]}}, a16};
        end
        SFA_OP_TRUNC: begin
          next_st.res = {{16{a32[15]}}, a32[15:0]};
        end
        SFA_OP_MSAMP: begin
          t = {{16{a16[15]}}, a16 & `SFA_SAMP_MASK};
          next_st.res = t;
        end
        SFA_OP_MPARAM: begin
          t = 32'(a16) & ~(32'hFFFFFFFF << shift_n[2:0]);
          next_st.res = t;
        end
        default: begin
          next_st.res = 32'h00000000;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign res_valid = st.vld;
  assign res32 = st.res;
  assign res16 = st.res[15:0];

  // checks on the issued operation one cycle later
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  a_fixed_latency: assert property (
    op_valid |=> res_valid ##1 ($past(op_valid) || !res_valid))
    else $error("result strobe not one cycle after issue");

  a_add16_pos_sat: assert property (
    op_valid && op == SFA_OP_ADD && sum16 > 17'sh07FFF |=> res16 == 16'h7FFF)
    else $error("short add did not clamp high");

  a_sub16_neg_sat: assert property (
    op_valid && op == SFA_OP_SUB && dif16 < -17'sh08000 |=> res16 == 16'h8000)
    else $error("short subtract did not clamp low");

  a_mult_min_min: assert property (
    op_valid && op == SFA_OP_MULT && a16 == 16'h8000 && b16 == 16'h8000
    |=> res16 == 16'h7FFF)
    else $error("scaled multiply of minimums wrong");

  a_multr_round: assert property (
    op_valid && op == SFA_OP_MULTR && a16 == 16'h4000 && b16 == 16'h0001
    |=> res16 == 16'h0001)
    else $error("rounded multiply did not round");

  a_abs_min: assert property (
    op_valid && op == SFA_OP_ABS && a16 == 16'h8000 |=> res16 == 16'h7FFF)
    else $error("absolute of minimum not clamped");

  a_div_equal: assert property (
    op_valid && op == SFA_OP_DIV && a16 == b16 && a16 != 16'h0000 && !a16[15]
    |=> res16 == 16'h7FFF)
    else $error("divide of equal operands wrong");

  a_lmult_double: assert property (
    op_valid && op == SFA_OP_LMULT && a16 == 16'h0003 && b16 == 16'hFFFE
    |=> res32 == 32'hFFFFFFF4)
    else $error("widening multiply not doubled");

  a_ladd_sat: assert property (
    op_valid && op == SFA_OP_LADD && sum32 > 33'sh07FFFFFFF
    |=> res32 == 32'h7FFFFFFF)
    else $error("long add did not clamp high");

  a_lsub_sat: assert property (
    op_valid && op == SFA_OP_LSUB && dif32 < -33'sh080000000
    |=> res32 == 32'h80000000)
    else $error("long subtract did not clamp low");

  a_norm_range: assert property (
    op_valid && op == SFA_OP_NORM && a32 != 32'h00000000
    |=> ((($past(a32) << res32[4:0]) ^ {{2{$past(a32[31])}}, 30'h0}) & 32'hC0000000)
        == 32'h40000000)
    else $error("normalization count off");

  a_norm_zero: assert property (
    op_valid && op == SFA_OP_NORM && a32 == 32'h00000000 |=> res32 == 32'h00000000)
    else $error("normalization of zero not zero");

  a_ext_sign: assert property (
    op_valid && op == SFA_OP_EXT
    |=> res32[15:0] == $past(a16) && res32[31:16] == {16{res32[15]}})
    else $error("short to long move not sign extended");

  a_trunc_low: assert property (
    op_valid && op == SFA_OP_TRUNC |=> res16 == $past(a32[15:0]))
    else $error("long to short move altered bits");

  a_samp_mask: assert property (
    op_valid && op == SFA_OP_MSAMP |=> res16[2:0] == 3'h0)
    else $error("sample don't-care bits leaked");

  a_shl_neg: assert property (
    op_valid && op == SFA_OP_SHL32 && shift_n == 8'hFF
    |=> res32 == {$past(a32[31]), $past(a32[31:1])})
    else $error("negative left shift not arithmetic right");

  a_shr_pos: assert property (
    op_valid && op == SFA_OP_SHR16 && shift_n == 8'h01
    |=> res16 == {$past(a16[15]), $past(a16[15:1])})
    else $error("right shift lost the sign");

  // main scenarios
  c_add_overflow: cover property (op_valid && op == SFA_OP_ADD && sum16 > 17'sh07FFF);
  c_div_issue: cover property (op_valid && op == SFA_OP_DIV ##1 res_valid);
  c_back_to_back: cover property (op_valid [*3] ##1 res_valid);
  c_norm_neg: cover property (op_valid && op == SFA_OP_NORM && a32[31]);

endmodule // sfa_alu

// ### testbench/sfa_caller.sv
`timescale 1ns/10ps
// caller model: one issue per go cycle, keeps the caller-side operand limits
module sfa_caller
  import sfa_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic arst_n, // async reset, active low
  input wire logic go, // issue request
  input wire logic clean, // zero non-valid sample bits
  input wire logic [4:0] op, // requested operation
  input wire logic [15:0] x16, // raw short a
  input wire logic [15:0] y16, // raw short b
  input wire logic [31:0] x32, // raw long a
  input wire logic [31:0] y32, // raw long b
  input wire logic bs, // short b for long ops
  input wire logic [7:0] sh, // shift count
  output logic op_valid, // issue strobe
  output logic [4:0] op_code, // operation
  output logic [15:0] a16, // short a
  output logic [15:0] b16, // short b
  output logic [31:0] a32, // long a
  output logic [31:0] b32, // long b
  output logic b_short, // short b select
  output logic [7:0] shift_n // shift count
);
  logic [15:0] xp;
  logic [15:0] yp;
  // divide operands forced positive
  assign xp = x16 & 16'h7FFF;
  assign yp = y16 & 16'h7FFF;
  // present after go; idle operands toggle so stale values never pass for live ones
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      op_valid <= 1'b0;
      op_code <= 5'h00;
      a16 <= 16'h0000;
      b16 <= 16'h0000;
      a32 <= 32'h0;
      b32 <= 32'h0;
      b_short <= 1'b0;
      shift_n <= 8'h00;
    end else if (go) begin
      op_valid <= 1'b1;
      op_code <= op;
      a16 <= x16;
      b16 <= y16;
      a32 <= x32;
      b32 <= y32;
      b_short <= bs;
      shift_n <= sh;
      if (clean && op == SFA_OP_MSAMP) a16 <= x16 & 16'hFFF8;
      if (op == SFA_OP_DIV) begin
        a16 <= xp > yp ? yp : xp;
        b16 <= xp > yp ? xp : yp;
      end
      if (op == SFA_OP_LMULT && x16 == 16'h8000 && y16 == 16'h8000) b16 <= 16'h8001;
    end else begin
      op_valid <= 1'b0;
      a16 <= ~a16;
      b16 <= ~b16;
      a32 <= ~a32;
      b32 <= ~b32;
    end
  end
endmodule // sfa_caller

// ### testbench/testbench.sv
`timescale 1ns/10ps
`include "sfa_regs.svh"
module testbench
  import sfa_pkg::*;
;
  logic mclk, arst_n, go, clean, bs, op_valid, b_short, res_valid, prev_ov;
  logic [4:0] op, op_code;
  logic [15:0] x16, y16, a16, b16, res16;
  logic [31:0] x32, y32, a32, b32, res32, exp_res, last_res;
  logic [7:0] sh, shift_n;
  logic [31:0] q[$];
  int err_count, n_tests;
  integer seed;

  sfa_caller u_sfa_caller (.mclk(mclk), .arst_n(arst_n), .go(go), .clean(clean), .op(op),
    .x16(x16), .y16(y16), .x32(x32), .y32(y32), .bs(bs), .sh(sh), .op_valid(op_valid),
    .op_code(op_code), .a16(a16), .b16(b16), .a32(a32), .b32(b32), .b_short(b_short),
    .shift_n(shift_n));
  sfa_alu u_sfa_alu (.mclk(mclk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
    .a16(a16), .b16(b16), .a32(a32), .b32(b32), .b_short(b_short), .shift_n(shift_n),
    .res_valid(res_valid), .res32(res32), .res16(res16));

  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // expected result of one issue
  function automatic logic [31:0] ref_res(input logic [4:0] op, input logic [15:0] a, b,
    input logic [31:0] la, lb, input logic bs, input logic [7:0] sh);
    logic signed [32:0] s;
    logic signed [31:0] p, v, e, lbb;
    int n, m;
    logic left;
    e = {{16{a[15]}}, a};
    lbb = bs ? {{16{b[15]}}, b} : lb;
    p = $signed(a) * $signed(b);
    n = int'($signed(sh));
    m = n < 0 ? -n : n;
    left = (op == SFA_OP_SHL16 || op == SFA_OP_SHL32) ^ (n < 0);
    v = (op == SFA_OP_SHL32 || op == SFA_OP_SHR32) ? la : e;
    if (left) v = m > 31 ? 32'h0 : v << m;
    else v = v >>> m;
    ref_res = 32'h0;
    case (op)
      SFA_OP_ADD, SFA_OP_SUB: begin
        s = (op == SFA_OP_ADD) ? $signed(a) + $signed(b) : $signed(a) - $signed(b);
        ref_res = (s > 32767) ? 32'h7FFF : (s < -32768) ? 32'hFFFF8000 : s[31:0];
      end
      SFA_OP_MULT, SFA_OP_MULTR: begin
        p = (p + (op == SFA_OP_MULTR ? 16384 : 0)) >>> 15;
        ref_res = (a == 16'h8000 && b == 16'h8000) ? 32'h7FFF : p;
      end
      SFA_OP_ABS: ref_res = a == 16'h8000 ? 32'h7FFF : a[15] ? -e : e;
      SFA_OP_DIV: ref_res = a == 16'h0 ? 32'h0 : a == b ? 32'h7FFF : {a, 15'h0} / b;
      SFA_OP_LMULT: ref_res = p <<< 1;
      SFA_OP_LADD, SFA_OP_LSUB: begin
        s = (op == SFA_OP_LADD) ? $signed(la) + lbb : $signed(la) - lbb;
        ref_res = (s[32] != s[31]) ? (s[32] ? 32'h80000000 : 32'h7FFFFFFF) : s[31:0];
      end
      SFA_OP_NORM: begin
        v = la;
        m = 0;
        if (la != 32'h0) while (m < 31 && v[31] == v[30]) begin
          v = v << 1;
          m++;
        end
        ref_res = m;
      end
      SFA_OP_SHL16, SFA_OP_SHR16: ref_res = {{16{v[15]}}, v[15:0]};
      SFA_OP_SHL32, SFA_OP_SHR32: ref_res = v;
      SFA_OP_EXT: ref_res = e;
      SFA_OP_TRUNC: ref_res = {{16{la[15]}}, la[15:0]};
      SFA_OP_MSAMP: ref_res = {{16{a[15]}}, a & `SFA_SAMP_MASK};
      SFA_OP_MPARAM: ref_res = {16'h0, a & ((16'h1 << sh[2:0]) - 16'h1)};
      default: ref_res = 32'h0;
    endcase
  endfunction

  task automatic chk32(input logic [31:0] got, exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk1(input logic got, exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one issue request, held for one edge
  task automatic iss(input logic [4:0] o, input logic [15:0] a, b, input logic [31:0] la, lb,
    input logic s = 1'b0, input logic [7:0] n = 8'h00);
    go <= 1'b1;
    op <= o;
    x16 <= a;
    y16 <= b;
    x32 <= la;
    y32 <= lb;
    bs <= s;
    sh <= n;
    @(posedge mclk);
  endtask

  // result monitor: strobe one cycle after issue, value from the reference
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q.delete();
      prev_ov = 1'b0;
      last_res = 32'h0;
    end else begin
      chk1(res_valid, prev_ov, "result strobe");
      if (res_valid === 1'b1) begin
        if (q.size() == 0) chk1(1'b1, 1'b0, "unexpected result");
        else begin
          exp_res = q.pop_front();
          chk32(res32, exp_res, "result");
          chk32({16'h0, res16}, {16'h0, exp_res[15:0]}, "short half");
          last_res = exp_res;
        end
      end else begin
        chk32(res32, last_res, "held result");
        chk32({16'h0, res16}, {16'h0, last_res[15:0]}, "held short half");
      end
      if (op_valid === 1'b1) begin
        q.push_back(ref_res(op_code, a16, b16, a32, b32, b_short, shift_n));
      end
      prev_ov = op_valid;
    end
  end

  initial begin
    repeat (5000) @(posedge mclk);
    chk1(1'b1, 1'b0, "run timeout");
    wrap_up();
  end

  initial begin
    seed = 32'hAC3E;
    err_count = 0;
    n_tests = 0;
    {arst_n, go, clean, bs, op, x16, y16, x32, y32, sh} = '0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    iss(SFA_OP_ADD, 16'h7000, 16'h2000, 32'h0, 32'h0);
    iss(SFA_OP_ADD, 16'h8000, 16'hFFFF, 32'h0, 32'h0);
    iss(SFA_OP_SUB, 16'h7FFF, 16'hFFFF, 32'h0, 32'h0);
    iss(SFA_OP_SUB, 16'h8000, 16'h0001, 32'h0, 32'h0);
    iss(SFA_OP_MULT, 16'h8000, 16'h8000, 32'h0, 32'h0);
    iss(SFA_OP_MULTR, 16'h8000, 16'h8000, 32'h0, 32'h0);
    iss(SFA_OP_MULTR, 16'h4000, 16'h0001, 32'h0, 32'h0);
    iss(SFA_OP_ABS, 16'h8000, 16'h0, 32'h0, 32'h0);
    iss(SFA_OP_DIV, 16'h1234, 16'h1234, 32'h0, 32'h0);
    iss(SFA_OP_LMULT, 16'h7FFF, 16'h8001, 32'h0, 32'h0);
    iss(SFA_OP_LMULT, 16'h0003, 16'hFFFE, 32'h0, 32'h0);
    iss(SFA_OP_LADD, 16'h0, 16'h0, 32'h7FFFFFFF, 32'h1);
    iss(SFA_OP_LSUB, 16'h0, 16'h0, 32'h80000000, 32'h1);
    iss(SFA_OP_NORM, 16'h0, 16'h0, 32'h0, 32'h0);
    iss(SFA_OP_NORM, 16'h0, 16'h0, 32'hFFFFFFFF, 32'h0);
    iss(SFA_OP_SHL16, 16'h0123, 16'h0, 32'h0, 32'h0, 1'b0, 8'hFD);
    iss(SFA_OP_SHR32, 16'h0, 16'h0, 32'h00F0000F, 32'h0, 1'b0, 8'hFC);
    iss(SFA_OP_SHL32, 16'h0, 16'h0, 32'h80000010, 32'h0, 1'b0, 8'hFF);
    iss(SFA_OP_SHR16, 16'h8002, 16'h0, 32'h0, 32'h0, 1'b0, 8'h01);
    iss(SFA_OP_EXT, 16'h8001, 16'h0, 32'h0, 32'h0);
    iss(SFA_OP_TRUNC, 16'h0, 16'h0, 32'h12348765, 32'h0);
    iss(SFA_OP_LADD, 16'h0, 16'hFFFF, 32'h5, 32'h0, 1'b1);
    iss(SFA_OP_MSAMP, 16'hFFFF, 16'h0, 32'h0, 32'h0);
    iss(SFA_OP_MPARAM, 16'h00FF, 16'h0, 32'h0, 32'h0, 1'b0, 8'h03);
    // random traffic over codes 0 to 18, every defined one plus unused code 18, with gaps
    for (int i = 0; i < 600; i++) begin
      clean <= 1'($random(seed));
      iss(5'($unsigned($random(seed)) % 19), 16'($random(seed)), 16'($random(seed)),
        $random(seed), $random(seed), 1'($random(seed)), 8'($random(seed)));
      if ($random(seed) % 4 == 0) begin
        go <= 1'b0;
        @(posedge mclk);
      end
    end
    go <= 1'b0;
    repeat (`SFA_LATENCY + 3) @(posedge mclk);
    chk32(32'(q.size()), 32'h0, "results missing");
    // reset in mid-run clears the outputs at once
    @(negedge mclk);
    arst_n = 1'b0;
    #1;
    chk32(res32, 32'h0, "reset result");
    chk1(res_valid, 1'b0, "reset strobe");
    @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    iss(SFA_OP_SUB, 16'h8000, 16'h7FFF, 32'h0, 32'h0);
    go <= 1'b0;
    repeat (`SFA_LATENCY + 3) @(posedge mclk);
    chk32(32'(q.size()), 32'h0, "results missing");
    wrap_up();
  end
endmodule // testbench
